/* magnetometer_pkg.sv */
// Constants shared by the magnetometer control block.
// Assumes a single 40 MHz system clock.
package magnetometer_pkg;
	localparam int unsigned clk_hz = 40000000;
	localparam logic [6:0] slave_address = 7'h30;
	localparam logic [7:0] offset_rate_and_axis_control = 8'h09;
	localparam logic [7:0] offset_continuous_and_irq_control = 8'h0a;
	localparam logic [7:0] offset_x_motion_limit = 8'h0b;
	localparam logic [7:0] offset_y_motion_limit = 8'h0c;
	localparam logic [7:0] offset_z_motion_limit = 8'h0d;
	localparam logic [7:0] offset_part_identifier = 8'h2f;
	localparam logic [7:0] offset_trigger_control = 8'h08;
	localparam logic [7:0] offset_status = 8'h07;
	// Arbitrary identification value
	localparam logic [7:0] part_identifier_value = 8'h5a;
	localparam logic [7:0] reset_register = 8'h00;
	// Field positions
	localparam int unsigned soft_restart_bit = 7;
	localparam int unsigned motion_irq_enable_bit = 5;
	localparam int unsigned done_irq_enable_bit = 6;
	localparam int unsigned motion_watch_start_bit = 1;
	localparam int unsigned measure_start_bit = 0;
	// Measurement times in microseconds, per speed code
	localparam int unsigned meas_time_us_0 = 10000;
	localparam int unsigned meas_time_us_1 = 5000;
	localparam int unsigned meas_time_us_2 = 2500;
	localparam int unsigned meas_time_us_3 = 1600;
	// One-third spacing between axis conversions, in cycles
	localparam int unsigned axis_gap_0 = meas_time_us_0 * (clk_hz / 1000000) / 3;
	localparam int unsigned axis_gap_1 = meas_time_us_1 * (clk_hz / 1000000) / 3;
	localparam int unsigned axis_gap_2 = meas_time_us_2 * (clk_hz / 1000000) / 3;
	localparam int unsigned axis_gap_3 = meas_time_us_3 * (clk_hz / 1000000) / 3;
	// Tick of 1/128 s for periodic rates
	localparam int unsigned tick_hz = 128;
	localparam int unsigned tick_cycles = clk_hz / tick_hz;
	localparam int unsigned power_up_us = 5000;
	localparam int unsigned power_up_cycles = power_up_us * (clk_hz / 1000000);
	typedef enum logic [2:0] {
		meas_idle, meas_convert, meas_gap, meas_finish
	} meas_state_t;
	typedef enum logic [2:0] {
		link_idle, link_address, link_address_ack, link_write,
		link_write_ack, link_read, link_read_ack
	} link_state_t;
endpackage

/* link_sync.sv */
// Two-stage synchroniser for a pin, with rise and fall pulses.
// Assumes the pin is asynchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none
module link_sync (
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic pin_in,
	output logic level_out,
	output logic rise_out,
	output logic fall_out
);
	logic meta;
	logic stable;
	logic prior;
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			meta <= 1'b1;
			stable <= 1'b1;
			prior <= 1'b1;
		end else begin
			meta <= pin_in;
			stable <= meta;
			prior <= stable;
		end
	end
	assign level_out = stable;
	assign rise_out = stable & ~prior;
	assign fall_out = ~stable & prior;
endmodule
`default_nettype wire

/* axis_sequencer.sv */
// Runs one measurement: converts enabled axes spaced by a third of the time.
// Assumes start_in is a single-cycle pulse on the system clock.
`timescale 1ns/1ps
`default_nettype none
module axis_sequencer
	import magnetometer_pkg::*;
(
	input wire logic clk_in,
	input wire logic reset_n_in,
	input wire logic start_in,
	input wire logic [1:0] speed_in,
	input wire logic [2:0] axis_off_in,
	output logic [2:0] convert_out,
	output logic done_out
);
	meas_state_t state;
	logic [1:0] axis;
	logic [18:0] count;
	logic [18:0] gap;
	always_comb begin
		unique case (speed_in)
			2'h0: gap = 19'(axis_gap_0);
			2'h1: gap = 19'(axis_gap_1);
			2'h2: gap = 19'(axis_gap_2);
			2'h3: gap = 19'(axis_gap_3);
		endcase
	end
	always_ff @(posedge clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			state <= meas_idle;
			axis <= 2'h0;
			count <= 19'h0;
			convert_out <= 3'h0;
			done_out <= 1'b0;
		end else begin
			convert_out <= 3'h0;
			done_out <= 1'b0;
			unique case (state)
				meas_idle: if (start_in) begin
					axis <= 2'h0;
					state <= meas_convert;
				end
				meas_convert: begin
					if (axis == 2'h3) begin
						state <= meas_finish;
					end else if (axis_off_in[axis]) begin
						axis <= axis + 2'h1; // RULE20
					end else begin
						convert_out[axis] <= 1'b1; // RULE1
						count <= gap;
						state <= meas_gap;
					end
				end
				meas_gap: begin
					if (count <= 19'h1) begin
						axis <= axis + 2'h1;
						state <= meas_convert;
					end else begin
						count <= count - 19'h1; // RULE1
					end
				end
				meas_finish: begin
					done_out <= 1'b1;
					state <= meas_idle;
				end
				default: state <= meas_idle;
			endcase
		end
	end
endmodule
`default_nettype wire

/* magnetometer_control.sv */
// Magnetometer control core: I2C slave, registers, sequencing, motion watch.
// Assumes SCL and SDA are asynchronous pins; axis samples come from the analog side.
// Function
// RULE1 - Axes converted in turn, one third apart
// RULE2 - Host waits measurement time before results
// RULE3 - Periodic rates assume slowest output speed
// RULE4 - Rate code zero disables periodic and motion
// RULE5 - Rate codes map 14 Hz down to 1/64 Hz
// RULE6 - Motion watch baselines, compares, flags, self-clears
// RULE7 - Motion enable drives interrupt on motion
// RULE8 - Done enable drives interrupt on completion
// RULE9 - Per-axis 8-bit threshold in 1 mG steps
// RULE10 - START and STOP framed while SCL high
// RULE11 - Eight bits plus acknowledge per byte
// RULE12 - Bits shifted most significant first
// RULE13 - Answer address 0110000, last bit read
// RULE14 - Master writes register index first
// RULE15 - Acknowledge by pulling SDA low
// RULE16 - Read via repeated START, device drives data
// RULE17 - Bursts reach consecutive registers
// RULE18 - Pointer advances after every byte
// RULE19 - STOP or new START ends transfer
// RULE20 - Disabled axis skipped, shorter measurement
// RULE21 - Soft restart clears registers, reruns power-up; the status register keeps its value
`timescale 1ns/1ps
`default_nettype none
module magnetometer_control
	import magnetometer_pkg::*;
#(
	parameter int unsigned power_up_count = power_up_cycles,
	parameter int unsigned tick_count = tick_cycles
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	output logic sda_out,
	output logic sda_oe_out,
	input wire logic [15:0] x_sample_in,
	input wire logic [15:0] y_sample_in,
	input wire logic [15:0] z_sample_in,
	output logic [2:0] convert_out,
	output logic irq_out,
	output logic ready_out
);
	logic scl;
	logic scl_rise;
	logic scl_fall;
	logic sda;
	logic sda_rise;
	logic sda_fall;
	link_state_t link;
	logic [3:0] bit_count;
	logic [7:0] shift;
	logic [7:0] pointer;
	logic index_phase;
	logic [7:0] trigger_control;
	logic [7:0] rate_and_axis_control;
	logic [7:0] continuous_and_irq_control;
	logic [7:0] x_motion_limit;
	logic [7:0] y_motion_limit;
	logic [7:0] z_motion_limit;
	logic [7:0] status;
	logic write_strobe;
	logic [7:0] write_data;
	logic [7:0] read_data;
	logic restart;
	logic [22:0] boot_count;
	logic [23:0] tick_timer;
	logic tick;
	logic [12:0] tick_index;
	logic periodic_due;
	logic seq_start;
	logic seq_done;
	logic [2:0] seq_convert;
	logic baseline_pending;
	logic [15:0] base_x;
	logic [15:0] base_y;
	logic [15:0] base_z;
	logic motion_hit;
	logic start_cond;
	logic stop_cond;

	link_sync scl_sync (.clk_in(mclk_in), .reset_n_in(reset_n_in), .pin_in(scl_in),
		.level_out(scl), .rise_out(scl_rise), .fall_out(scl_fall));
	link_sync sda_sync (.clk_in(mclk_in), .reset_n_in(reset_n_in), .pin_in(sda_in),
		.level_out(sda), .rise_out(sda_rise), .fall_out(sda_fall));

	assign start_cond = sda_fall & scl; // RULE10
	assign stop_cond = sda_rise & scl; // RULE10

	// Register read mux
	always_comb begin
		unique case (pointer)
			offset_status: read_data = status;
			offset_part_identifier: read_data = part_identifier_value;
			default: read_data = 8'h00;
		endcase
	end

	// Serial link
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			link <= link_idle;
			bit_count <= 4'h0;
			shift <= 8'h00;
			pointer <= 8'h00;
			index_phase <= 1'b0;
			sda_out <= 1'b1;
			sda_oe_out <= 1'b0;
			write_strobe <= 1'b0;
			write_data <= 8'h00;
		end else begin
			write_strobe <= 1'b0;
			if (start_cond) begin
				link <= link_address; // RULE19
				bit_count <= 4'h0;
				sda_oe_out <= 1'b0;
			end else if (stop_cond) begin
				link <= link_idle; // RULE19
				sda_oe_out <= 1'b0;
			end else if (scl_rise) begin
				unique case (link)
					link_address, link_write: begin
						shift <= {shift[6:0], sda}; // RULE12
						bit_count <= bit_count + 4'h1; // RULE11
					end
					link_read: bit_count <= bit_count + 4'h1;
					link_read_ack: if (sda) begin
						link <= link_idle;
					end
					default: ;
				endcase
			end else if (scl_fall) begin
				unique case (link)
					link_address: if (bit_count == 4'h8) begin
						if (shift[7:1] == slave_address) begin // RULE13
							sda_out <= 1'b0; // RULE15
							sda_oe_out <= 1'b1;
							index_phase <= ~shift[0]; // RULE14
							link <= link_address_ack;
						end else begin
							link <= link_idle;
						end
					end
					link_address_ack: begin
						bit_count <= 4'h0;
						if (shift[0]) begin
							sda_out <= read_data[7]; // RULE16
							shift <= {read_data[6:0], 1'b0};
							link <= link_read;
						end else begin
							sda_oe_out <= 1'b0;
							link <= link_write;
						end
					end
					link_write: if (bit_count == 4'h8) begin
						sda_out <= 1'b0;
						sda_oe_out <= 1'b1;
						if (index_phase) begin
							pointer <= shift; // RULE14
						end else begin
							write_strobe <= 1'b1;
							write_data <= shift;
						end
						link <= link_write_ack;
					end
					link_write_ack: begin
						sda_oe_out <= 1'b0;
						bit_count <= 4'h0;
						if (index_phase) begin
							index_phase <= 1'b0;
						end else begin
							pointer <= pointer + 8'h01; // RULE18
						end
						link <= link_write; // RULE17
					end
					link_read: begin
						if (bit_count == 4'h8) begin
							sda_oe_out <= 1'b0;
							pointer <= pointer + 8'h01; // RULE18
							link <= link_read_ack;
						end else begin
							sda_out <= shift[7]; // RULE12
							shift <= {shift[6:0], 1'b0};
						end
					end
					link_read_ack: begin
						bit_count <= 4'h0;
						sda_out <= read_data[7]; // RULE17
						sda_oe_out <= 1'b1;
						shift <= {read_data[6:0], 1'b0};
						link <= link_read;
					end
					default: ;
				endcase
			end
		end
	end

	// Register writes and restart
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			trigger_control <= reset_register;
			rate_and_axis_control <= reset_register;
			continuous_and_irq_control <= reset_register;
			x_motion_limit <= reset_register;
			y_motion_limit <= reset_register;
			z_motion_limit <= reset_register;
			restart <= 1'b0;
		end else begin
			restart <= 1'b0;
			trigger_control[measure_start_bit] <= 1'b0;
			if (motion_hit) begin
				trigger_control[motion_watch_start_bit] <= 1'b0; // RULE6
			end
			if (write_strobe) begin
				unique case (pointer)
					offset_trigger_control: trigger_control <= write_data;
					offset_rate_and_axis_control: begin
						if (write_data[soft_restart_bit]) begin
							restart <= 1'b1; // RULE21
						end else begin
							rate_and_axis_control <= write_data;
						end
					end
					offset_continuous_and_irq_control: continuous_and_irq_control <= write_data;
					offset_x_motion_limit: x_motion_limit <= write_data; // RULE9
					offset_y_motion_limit: y_motion_limit <= write_data; // RULE9
					offset_z_motion_limit: z_motion_limit <= write_data; // RULE9
					default: ;
				endcase
			end
			if (restart) begin
				trigger_control <= reset_register; // RULE21
				rate_and_axis_control <= reset_register;
				continuous_and_irq_control <= reset_register;
				x_motion_limit <= reset_register;
				y_motion_limit <= reset_register;
				z_motion_limit <= reset_register;
			end
		end
	end

	// Power-up wait
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			boot_count <= 23'h0;
			ready_out <= 1'b0;
		end else if (restart) begin
			boot_count <= 23'h0; // RULE21
			ready_out <= 1'b0;
		end else if (boot_count >= 23'(power_up_count)) begin
			ready_out <= 1'b1;
		end else begin
			boot_count <= boot_count + 23'h1;
		end
	end

	// Periodic tick at 128 Hz, rate code picks the interval
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			tick_timer <= 24'h0;
			tick <= 1'b0;
			tick_index <= 13'h0;
		end else begin
			tick <= 1'b0;
			if (tick_timer >= 24'(tick_count - 1)) begin
				tick_timer <= 24'h0;
				tick <= 1'b1;
				tick_index <= tick_index + 13'h1;
			end else begin
				tick_timer <= tick_timer + 24'h1;
			end
		end
	end

	// Intervals in 1/128 s ticks, speed code 00 assumed
	always_comb begin
		unique case (continuous_and_irq_control[3:0]) // RULE3
			4'h1: periodic_due = tick && (tick_index % 13'h9 == 13'h0); // RULE5
			4'h2: periodic_due = tick && (tick_index % 13'h1a == 13'h0);
			4'h3: periodic_due = tick && (tick_index % 13'h3a == 13'h0);
			4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha: periodic_due = tick
				&& ((tick_index & 13'((14'h1 << (continuous_and_irq_control[3:0] + 4'h3)) - 14'h1))
				== 13'h0); // RULE5
			default: periodic_due = 1'b0; // RULE4
		endcase
	end

	assign seq_start = ready_out & (trigger_control[measure_start_bit] | periodic_due);

	axis_sequencer sequencer (.clk_in(mclk_in), .reset_n_in(reset_n_in), .start_in(seq_start),
		.speed_in(rate_and_axis_control[1:0]), .axis_off_in(rate_and_axis_control[4:2]),
		.convert_out(seq_convert), .done_out(seq_done));

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			convert_out <= 3'h0;
		end else begin
			convert_out <= seq_convert;
		end
	end

	// Motion watch
	always_comb begin
		motion_hit = 1'b0;
		if (seq_done && trigger_control[motion_watch_start_bit] && !baseline_pending
			&& continuous_and_irq_control[3:0] != 4'h0) begin
			motion_hit = (x_sample_in - base_x > {8'h00, x_motion_limit} && base_x - x_sample_in >
				{8'h00, x_motion_limit}) | (16'(x_sample_in - base_x) > {8'h00, x_motion_limit}
				&& x_sample_in > base_x) | (16'(base_x - x_sample_in) > {8'h00, x_motion_limit}
				&& base_x > x_sample_in) | (y_sample_in > base_y && 16'(y_sample_in - base_y) >
				{8'h00, y_motion_limit}) | (base_y > y_sample_in && 16'(base_y - y_sample_in) >
				{8'h00, y_motion_limit}) | (z_sample_in > base_z && 16'(z_sample_in - base_z) >
				{8'h00, z_motion_limit}) | (base_z > z_sample_in && 16'(base_z - z_sample_in) >
				{8'h00, z_motion_limit}); // RULE6
		end
	end

	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			baseline_pending <= 1'b0;
			base_x <= 16'h0;
			base_y <= 16'h0;
			base_z <= 16'h0;
		end else begin
			if (write_strobe && pointer == offset_trigger_control && write_data[motion_watch_start_bit]) begin
				baseline_pending <= 1'b1;
			end else if (seq_done && baseline_pending) begin
				baseline_pending <= 1'b0; // RULE6
				base_x <= x_sample_in;
				base_y <= y_sample_in;
				base_z <= z_sample_in;
			end
		end
	end

	// Status and interrupt; set wins over clear on read
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			status <= 8'h00;
			irq_out <= 1'b0;
		end else begin
			if (link == link_read && scl_fall && bit_count == 4'h8 && pointer == offset_status) begin
				status <= 8'h00;
			end
			if (seq_done) begin
				status[0] <= 1'b1;
			end
			if (motion_hit) begin
				status[1] <= 1'b1;
			end
			irq_out <= (continuous_and_irq_control[done_irq_enable_bit] & (status[0] | seq_done)) // RULE8
				| (continuous_and_irq_control[motion_irq_enable_bit] & (status[1] | motion_hit)); // RULE7
		end
	end
endmodule
`default_nettype wire

/* magnetometer_control_sva.sv */
// Port assertions for the magnetometer control core.
// Assumes binding onto magnetometer_control.
`timescale 1ns/1ps
`default_nettype none
module magnetometer_control_sva
	import magnetometer_pkg::*;
#(
	parameter int unsigned power_up_count = 20,
	parameter int unsigned tick_count = 50
) (
	input wire logic mclk_in,
	input wire logic reset_n_in,
	input wire logic scl_in,
	input wire logic sda_in,
	input wire logic sda_out,
	input wire logic sda_oe_out,
	input wire logic [15:0] x_sample_in,
	input wire logic [15:0] y_sample_in,
	input wire logic [15:0] z_sample_in,
	input wire logic [2:0] convert_out,
	input wire logic irq_out,
	input wire logic ready_out
);
	int unsigned low_cnt;
	int unsigned since_conv;
	logic conv_seen;
	default clocking @(posedge mclk_in); endclocking
	default disable iff (!reset_n_in);
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) low_cnt <= 0;
		else if (ready_out) low_cnt <= 0;
		else low_cnt <= low_cnt + 1;
	end
	always_ff @(posedge mclk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			since_conv <= 0;
			conv_seen <= 1'b0;
		end else if (convert_out != 3'b000) begin
			since_conv <= 0;
			conv_seen <= 1'b1;
		end else since_conv <= since_conv + 1;
	end
	property p_conv_onehot;
		$onehot0(convert_out);
	endproperty
	a_conv_onehot: assert property (p_conv_onehot) else $error("two axes at once");
	property p_conv_pulse;
		convert_out != 3'b000 |=> convert_out == 3'b000 [*8];
	endproperty
	a_conv_pulse: assert property (p_conv_pulse) else $error("axis pulse too long");
	property p_conv_gap;
		(convert_out != 3'b000) && conv_seen |-> since_conv >= axis_gap_3 - 3;
	endproperty
	a_conv_gap: assert property (p_conv_gap) else $error("axes too close");
	property p_conv_ready;
		convert_out != 3'b000 |-> ready_out;
	endproperty
	a_conv_ready: assert property (p_conv_ready) else $error("convert before ready");
	property p_irq_ready;
		$rose(irq_out) |-> ready_out;
	endproperty
	a_irq_ready: assert property (p_irq_ready) else $error("irq before ready");
	property p_ready_wait;
		$rose(ready_out) |-> low_cnt >= power_up_count - 2;
	endproperty
	a_ready_wait: assert property (p_ready_wait) else $error("ready too early");
	property p_oe_scl_low;
		$changed(sda_oe_out) |-> !scl_in;
	endproperty
	a_oe_scl_low: assert property (p_oe_scl_low) else $error("drive change in scl high");
	property p_data_stable;
		sda_oe_out && scl_in |-> $stable(sda_out) && $stable(sda_oe_out);
	endproperty
	a_data_stable: assert property (p_data_stable) else $error("data moved in scl high");
	property p_frame_release;
		scl_in && $past(scl_in) && $changed(sda_in) |-> !sda_oe_out;
	endproperty
	a_frame_release: assert property (p_frame_release) else $error("driving at frame edge");
endmodule
bind magnetometer_control magnetometer_control_sva #(.power_up_count(power_up_count),
	.tick_count(tick_count)) i_magnetometer_control_sva (.mclk_in(mclk_in),
	.reset_n_in(reset_n_in), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
	.sda_oe_out(sda_oe_out), .x_sample_in(x_sample_in), .y_sample_in(y_sample_in),
	.z_sample_in(z_sample_in), .convert_out(convert_out), .irq_out(irq_out),
	.ready_out(ready_out));
`default_nettype wire

/* host_model.sv */
// I2C master model: drives SCL and pulls SDA low when asked.
// Assumes the bench resolves SDA with a pull-up; SCL idles high.
`timescale 1ns/1ps
`default_nettype none
module host_model (
	output logic scl_out,
	output logic sda_low_out,
	input wire logic sda_in
);
	initial begin
		scl_out = 1'b1;
		sda_low_out = 1'b0;
	end
	task automatic start();
		#20 sda_low_out = 1'b0;
		#100 scl_out = 1'b1;
		#40 sda_low_out = 1'b1;
		#40 scl_out = 1'b0;
	endtask
	task automatic stop();
		#20 sda_low_out = 1'b1;
		#100 scl_out = 1'b1;
		#40 sda_low_out = 1'b0;
		#40;
	endtask
	task automatic bit_io(input logic b, output logic r);
		#20 sda_low_out = !b;
		#100 scl_out = 1'b1;
		#40 r = sda_in;
		#40 scl_out = 1'b0;
	endtask
	// Eight bits, then the acknowledge bit
	task automatic xfer(input logic [7:0] tx, input logic ack_in, output logic [7:0] rx,
		output logic ack_out);
		for (int i = 7; i >= 0; i--) bit_io(tx[i], rx[i]);
		bit_io(ack_in, ack_out);
	endtask
endmodule
`default_nettype wire

/* magnetometer_control_tb.sv */
// Self-checking bench for the magnetometer control core.
// Assumes host_model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
module magnetometer_control_tb
	import magnetometer_pkg::*;
;
	localparam int unsigned pwr = 20;
	logic mclk_in = 1'b0;
	logic reset_n_in = 1'b0;
	logic scl, sda_low, sda_o, sda_oe, irq, ready, ack;
	wire logic sda_wire;
	logic [15:0] xs = 16'h0000;
	logic [15:0] ys = 16'h0000;
	logic [15:0] zs = 16'h0000;
	logic [2:0] convert;
	logic [7:0] d0, d1;
	int miscompares = 0;
	int n_tests = 0;
	int cycles = 0;
	int low_len = 0;
	int conv_n[3];
	int conv_at[3];
	int k;
	always #12.5 mclk_in = ~mclk_in;
	assign sda_wire = !(sda_low || (sda_oe && !sda_o));
	host_model i_host_model (.scl_out(scl), .sda_low_out(sda_low), .sda_in(sda_wire));
	magnetometer_control #(.power_up_count(pwr), .tick_count(50)) i_magnetometer_control (
		.mclk_in(mclk_in), .reset_n_in(reset_n_in), .scl_in(scl), .sda_in(sda_wire),
		.sda_out(sda_o), .sda_oe_out(sda_oe), .x_sample_in(xs), .y_sample_in(ys),
		.z_sample_in(zs), .convert_out(convert), .irq_out(irq), .ready_out(ready));
	task final_report();
		$display("miscompares=%0d n_tests=%0d", miscompares, n_tests);
		if (miscompares == 0 && n_tests > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge mclk_in) begin
		cycles++;
		if (!ready) low_len++;
		for (int i = 0; i < 3; i++) if (convert[i]) begin
			conv_n[i]++;
			conv_at[i] = cycles;
		end
		if (cycles == 100000) begin
			miscompares++;
			final_report();
		end
	end
	task check(input logic [7:0] seen, input logic [7:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	function logic [7:0] exp_read(input logic [7:0] idx);
		return (idx == offset_part_identifier) ? part_identifier_value : 8'h00;
	endfunction
	function int gap_for(input logic [1:0] s);
		return (s == 2'b00) ? axis_gap_0 : (s == 2'b01) ? axis_gap_1 :
			(s == 2'b10) ? axis_gap_2 : axis_gap_3;
	endfunction
	task wr(input logic [7:0] idx, input logic [7:0] data);
		logic [7:0] rx;
		logic a;
		i_host_model.start();
		i_host_model.xfer({slave_address, 1'b0}, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.xfer(idx, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.xfer(data, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.stop();
	endtask
	task wr2(input logic [7:0] idx, input logic [7:0] da, input logic [7:0] db);
		logic [7:0] rx;
		logic a;
		i_host_model.start();
		i_host_model.xfer({slave_address, 1'b0}, 1'b1, rx, a);
		i_host_model.xfer(idx, 1'b1, rx, a);
		i_host_model.xfer(da, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.xfer(db, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.stop();
	endtask
	task rd(input logic [7:0] idx, output logic [7:0] r0, output logic [7:0] r1);
		logic [7:0] rx;
		logic a;
		i_host_model.start();
		i_host_model.xfer({slave_address, 1'b0}, 1'b1, rx, a);
		i_host_model.xfer(idx, 1'b1, rx, a);
		i_host_model.start();
		i_host_model.xfer({slave_address, 1'b1}, 1'b1, rx, a);
		check(8'(a), 8'h00);
		i_host_model.xfer(8'hff, 1'b0, r0, a);
		i_host_model.xfer(8'hff, 1'b1, r1, a);
		i_host_model.stop();
	endtask
	initial begin
		logic [7:0] wa;
		void'($urandom(93576));
		repeat (8) @(posedge mclk_in);
		#1 reset_n_in = 1'b1;
		check(8'({sda_oe, irq, ready, convert}), 8'h00);
		check(8'(sda_o), 8'h01);
		for (int i = 0; i < 200 && !ready; i++) @(posedge mclk_in);
		#1 rd(offset_part_identifier, d0, d1);
		check(d0, exp_read(offset_part_identifier));
		check(d1, exp_read(offset_part_identifier + 8'h01));
		repeat (3) begin
			wa = 8'($urandom_range(255, 0));
			if (wa[7:1] == slave_address) wa[7:1] = ~slave_address;
			i_host_model.start();
			i_host_model.xfer(wa, 1'b1, d0, ack);
			check(8'(ack), 8'h01);
			i_host_model.stop();
		end
		@(posedge mclk_in);
		#1 xs = 16'($urandom_range(32767, 0));
		ys = 16'($urandom);
		zs = 16'($urandom);
		wr(offset_continuous_and_irq_control, 8'h40);
		wr(offset_rate_and_axis_control, 8'h07);
		wr(offset_trigger_control, 8'h01);
		for (int i = 0; i < 4 * gap_for(2'b11) && !irq; i++) @(posedge mclk_in);
		#1 check(8'(irq), 8'h01);
		check(8'(conv_n[0]), 8'h00);
		check(8'(conv_n[1] + conv_n[2] * 2), 8'h03);
		check(8'((conv_at[2] - conv_at[1] - gap_for(2'b11)) inside {[-2:2]}), 8'h01);
		rd(offset_status, d0, d1);
		check(8'(d0[0]), 8'h01);
		repeat (2000) @(posedge mclk_in);
		#1 check(8'(irq), 8'h00);
		check(8'(conv_n[1] + conv_n[2]), 8'h02);
		wa = 8'($urandom_range(255, 0));
		wr(offset_rate_and_axis_control, 8'h1f);
		wr2(offset_continuous_and_irq_control, 8'h21, wa);
		wr(offset_trigger_control, 8'h02);
		repeat (1000) @(posedge mclk_in);
		#1 xs = xs + 16'(wa);
		repeat (1000) @(posedge mclk_in);
		#1 check(8'(irq), 8'h00);
		xs = xs + 16'h0001;
		for (int i = 0; i < 1000 && !irq; i++) @(posedge mclk_in);
		#1 check(8'(irq), 8'h01);
		rd(offset_status, d0, d1);
		check(8'(d0[1]), 8'h01);
		repeat (1000) @(posedge mclk_in);
		#1 check(8'(irq), 8'h00);
		k = low_len;
		wr(offset_rate_and_axis_control, 8'h80);
		for (int i = 0; i < 50 && ready; i++) @(posedge mclk_in);
		for (int i = 0; i < 500 && !ready; i++) @(posedge mclk_in);
		#1 check(8'((low_len - k) inside {[pwr - 2:pwr + 4]} && ready), 8'h01);
		rd(offset_part_identifier, d0, d1);
		check(d0, exp_read(offset_part_identifier));
		final_report();
	end
endmodule
`default_nettype wire
